//--- core/stc_cal_timer.sv
// watchdog that bounds the length of one calibration run
`timescale 1ns/10ps
module stc_cal_timer import stc_pkg::*; #(
	parameter int P_BOUND_BASE = BOUND_BASE
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_run,
	input wire logic [1:0] i_avg,
	input wire logic [1:0] i_hdur,
	output logic o_expired
);
	logic [BOUND_W-1:0] cnt_q;
	logic [BOUND_W-1:0] cnt_d;
	logic [BOUND_W-1:0] bound;
	logic [4:0] shift;

	always_comb begin
		shift = 5'(({3'h0, i_avg} + {3'h0, i_hdur} + 5'h02) << 1);
		bound = BOUND_W'(P_BOUND_BASE) << shift;
		cnt_d = i_run ? cnt_q + 29'h0000_0001 : '0;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// the run is cut when its cycle budget is used up
	assign o_expired = i_run && (cnt_q >= bound - 29'h0000_0002);
endmodule // stc_cal_timer

//--- core/stc_pkg.sv
// shared constants and types for the sysref timing calibration block
package stc_pkg;

	localparam int ADDR_W = 12;
	localparam int DATA_W = 24;
	localparam int DELAY_W = 17;
	localparam int BOUND_W = 29;
	localparam int WAIT_W = 16;

	// register offsets
	localparam logic [ADDR_W-1:0] OFF_ENABLE = 12'h02b0;
	localparam logic [ADDR_W-1:0] OFF_CONFIG = 12'h02b1;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h02b2;
	localparam logic [ADDR_W-1:0] OFF_MANUAL = 12'h02b5;
	localparam logic [ADDR_W-1:0] OFF_NOISE = 12'h02c0;
	localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 12'h02c1;
	localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 12'h02c2;

	// field positions
	localparam int EN_BIT = 0;
	localparam int AVG_LSB = 2;
	localparam int HDUR_LSB = 0;
	localparam int NOISE_BIT = 4;
	localparam int DONE_BIT = 17;
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_FAIL_BIT = 1;
	localparam int IRQ_W = 2;

	// reset values
	localparam logic [7:0] ENABLE_RST = 8'h00;
	localparam logic [7:0] CONFIG_RST = 8'h05;
	localparam logic [7:0] NOISE_RST = 8'h00;
	localparam logic [DELAY_W-1:0] MANUAL_RST = 17'h0_0000;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 2'h0;

	// timing counts in device clock cycles
	localparam int BOUND_BASE = 384 * 19;
	localparam int MAX_PER_0 = 128;
	localparam int MAX_PER_1 = 1664;
	localparam int MAX_PER_2 = 7808;
	localparam int MAX_PER_3 = 32384;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WAIT_EDGE,
		ST_ACCUM,
		ST_DONE,
		ST_FAIL
	} stc_state_e;

endpackage

//--- core/stc_sysref_cal.sv
// sysref timing calibration control: registers, sequencer, delay select, interrupt
//
// What this block does
// - enable clear selects the manual delay register; no automatic adjustment runs.
// - enable set selects the calibrated delay; manual register value is ignored.
// - only a 0-to-1 enable change starts calibration; rewrites never restart it.
// - averaging field bits 3:2, reset 1, codes give 4/16/64/256 averages.
// - accumulation field bits 1:0, reset 1, codes give 4/16/64/256 cycles.
// - accumulation codes cover sysref periods up to 128/1664/7808/32384 cycles.
// - calibration ends within 384*19*4^(avg+accum+2) device clock cycles.
// - noise control bit 4 turns core supply rail noise suppression on or off.
// - completion bit 17 reads one only while enabled and calibration finished.
// - 17-bit result: bit 16 inversion, 15:8 coarse, 7:0 fine; valid when complete.
`timescale 1ns/10ps
module stc_sysref_cal import stc_pkg::*; #(
	parameter int P_BOUND_BASE = BOUND_BASE,
	parameter int P_MAX_PER_0 = MAX_PER_0,
	parameter int P_MAX_PER_1 = MAX_PER_1,
	parameter int P_MAX_PER_2 = MAX_PER_2,
	parameter int P_MAX_PER_3 = MAX_PER_3
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic i_sysref,
	output logic [DATA_W-1:0] o_rdata,
	output logic [DELAY_W-1:0] o_sample_delay,
	output logic o_supply_noise_suppress,
	output logic o_cal_busy,
	output logic o_irq
);
	// register state
	logic [7:0] enable_q;
	logic [7:0] enable_d;
	logic enable_prev_q;
	logic enable_prev_d;
	logic [7:0] config_q;
	logic [7:0] config_d;
	logic [7:0] noise_q;
	logic [7:0] noise_d;
	logic [DELAY_W-1:0] manual_q;
	logic [DELAY_W-1:0] manual_d;
	logic [IRQ_W-1:0] irq_stat_q;
	logic [IRQ_W-1:0] irq_stat_d;
	logic [IRQ_W-1:0] irq_mask_q;
	logic [IRQ_W-1:0] irq_mask_d;
	logic [DATA_W-1:0] rdata_q;
	logic [DATA_W-1:0] rdata_d;
	logic [DELAY_W-1:0] delay_q;
	logic [DELAY_W-1:0] delay_d;

	// sequencer state
	stc_state_e st_q;
	stc_state_e st_d;
	logic [WAIT_W-1:0] wait_q;
	logic [WAIT_W-1:0] wait_d;
	logic [8:0] win_q;
	logic [8:0] win_d;
	logic [8:0] high_q;
	logic [8:0] high_d;
	logic [8:0] meas_q;
	logic [8:0] meas_d;
	// 256 windows of at most 256 high cycles fit the 17-bit sum
	logic [16:0] sum_q;
	logic [16:0] sum_d;
	logic [7:0] coarse_q;
	logic [7:0] coarse_d;
	logic [DELAY_W-1:0] result_q;
	logic [DELAY_W-1:0] result_d;

	logic cal_en;
	logic start;
	logic [1:0] avg_code;
	logic [1:0] hdur_code;
	logic [8:0] win_last;
	logic [8:0] meas_last;
	logic [WAIT_W-1:0] max_per;
	logic sys_level;
	logic sys_rise;
	logic running;
	logic expired;
	logic [8:0] high_now;
	logic [16:0] sum_now;
	logic [16:0] avg_val;
	logic ev_done;
	logic ev_fail;
	logic done_flag;

	stc_sysref_edge u_edge (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_sysref(i_sysref),
		.o_level(sys_level),
		.o_rise(sys_rise)
	);

	// watchdog counts only while the sequencer is busy, so idle time never eats the budget
	stc_cal_timer #(
		.P_BOUND_BASE(P_BOUND_BASE)
	) u_timer (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_run(running),
		.i_avg(avg_code),
		.i_hdur(hdur_code),
		.o_expired(expired)
	);

	assign cal_en = enable_q[EN_BIT];
	// registered previous bit keeps a rewrite of one from looking like a new start
	assign start = cal_en & ~enable_prev_q;
	assign avg_code = config_q[AVG_LSB+1:AVG_LSB];
	assign hdur_code = config_q[HDUR_LSB+1:HDUR_LSB];
	assign running = (st_q == ST_WAIT_EDGE) || (st_q == ST_ACCUM);
	assign done_flag = cal_en && (st_q == ST_DONE);

	// window of 4^(code+1) cycles and 4^(code+1) measurements
	assign win_last = 9'((17'h0_0001 << (({2'b00, hdur_code} + 4'h1) << 1)) - 17'h0_0001);
	assign meas_last = 9'((17'h0_0001 << (({2'b00, avg_code} + 4'h1) << 1)) - 17'h0_0001);

	// longest sysref gap the chosen accumulation length can track
	always_comb begin
		unique case (hdur_code)
			2'h0: max_per = WAIT_W'(P_MAX_PER_0);
			2'h1: max_per = WAIT_W'(P_MAX_PER_1);
			2'h2: max_per = WAIT_W'(P_MAX_PER_2);
			2'h3: max_per = WAIT_W'(P_MAX_PER_3);
		endcase
	end

	// calibration sequencer
	always_comb begin
		st_d = st_q;
		wait_d = wait_q;
		win_d = win_q;
		high_d = high_q;
		meas_d = meas_q;
		sum_d = sum_q;
		coarse_d = coarse_q;
		result_d = result_q;
		ev_done = 1'b0;
		ev_fail = 1'b0;
		high_now = high_q + {8'h00, sys_level};
		sum_now = sum_q + {8'h00, high_now};
		avg_val = sum_now >> (({3'h0, avg_code} + 5'h01) << 1);
		if (!cal_en) begin
			st_d = ST_IDLE;
		end else begin
			unique case (st_q)
				ST_IDLE: begin
					if (start) begin
						st_d = ST_WAIT_EDGE;
						wait_d = '0;
						meas_d = '0;
						sum_d = '0;
					end
				end
				ST_WAIT_EDGE: begin
					wait_d = wait_q + 16'h0001;
					if (expired) begin
						st_d = ST_FAIL;
						ev_fail = 1'b1;
					end else if (sys_rise) begin
						st_d = ST_ACCUM;
						win_d = '0;
						high_d = '0;
						coarse_d = wait_q[7:0];
					end else if (wait_q >= max_per) begin
						// sysref slower than the accumulation can cover
						st_d = ST_FAIL;
						ev_fail = 1'b1;
					end
				end
				ST_ACCUM: begin
					win_d = win_q + 9'h001;
					high_d = high_now;
					if (expired) begin
						st_d = ST_FAIL;
						ev_fail = 1'b1;
					end else if (win_q == win_last) begin
						sum_d = sum_now;
						meas_d = meas_q + 9'h001;
						wait_d = '0;
						if (meas_q == meas_last) begin
							st_d = ST_DONE;
							ev_done = 1'b1;
							result_d = {avg_val[8], coarse_q, avg_val[7:0]};
						end else begin
							st_d = ST_WAIT_EDGE;
						end
					end
				end
				// done and fail hold until enable drops, so the result stays readable
				ST_DONE: st_d = ST_DONE;
				ST_FAIL: st_d = ST_FAIL;
				// codes outside the enum fall back to idle
				default: st_d = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st_q <= ST_IDLE;
			wait_q <= '0;
			win_q <= '0;
			high_q <= '0;
			meas_q <= '0;
			sum_q <= '0;
			coarse_q <= '0;
			result_q <= '0;
		end else begin
			st_q <= st_d;
			wait_q <= wait_d;
			win_q <= win_d;
			high_q <= high_d;
			meas_q <= meas_d;
			sum_q <= sum_d;
			coarse_q <= coarse_d;
			result_q <= result_d;
		end
	end

	// register file and read port
	always_comb begin
		enable_d = enable_q;
		enable_prev_d = enable_q[EN_BIT];
		config_d = config_q;
		noise_d = noise_q;
		manual_d = manual_q;
		irq_mask_d = irq_mask_q;
		irq_stat_d = irq_stat_q;
		rdata_d = '0;
		if (i_wr) begin
			unique case (i_addr)
				OFF_ENABLE: enable_d = i_wdata[7:0];
				OFF_CONFIG: config_d = i_wdata[7:0];
				OFF_NOISE: noise_d = i_wdata[7:0];
				OFF_MANUAL: manual_d = i_wdata[DELAY_W-1:0];
				OFF_IRQ_MASK: irq_mask_d = i_wdata[IRQ_W-1:0];
				OFF_IRQ_STAT: irq_stat_d = irq_stat_q & ~i_wdata[IRQ_W-1:0];
				default: ;
			endcase
		end
		// a new event wins over a simultaneous clear
		irq_stat_d[IRQ_DONE_BIT] = irq_stat_d[IRQ_DONE_BIT] | ev_done;
		irq_stat_d[IRQ_FAIL_BIT] = irq_stat_d[IRQ_FAIL_BIT] | ev_fail;
		if (i_rd) begin
			unique case (i_addr)
				OFF_ENABLE: rdata_d = {16'h0000, enable_q};
				OFF_CONFIG: rdata_d = {16'h0000, config_q};
				OFF_STATUS: rdata_d = {6'h00, done_flag, result_q};
				OFF_MANUAL: rdata_d = {7'h00, manual_q};
				OFF_NOISE: rdata_d = {16'h0000, noise_q};
				OFF_IRQ_STAT: rdata_d = {22'h00_0000, irq_stat_q};
				OFF_IRQ_MASK: rdata_d = {22'h00_0000, irq_mask_q};
				default: rdata_d = '0;
			endcase
		end
		// manual value stands in whenever calibration is off
		delay_d = cal_en ? result_q : manual_q;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			enable_q <= ENABLE_RST;
			enable_prev_q <= 1'b0;
			config_q <= CONFIG_RST;
			noise_q <= NOISE_RST;
			manual_q <= MANUAL_RST;
			irq_stat_q <= '0;
			irq_mask_q <= IRQ_MASK_RST;
			rdata_q <= '0;
			delay_q <= MANUAL_RST;
		end else begin
			enable_q <= enable_d;
			enable_prev_q <= enable_prev_d;
			config_q <= config_d;
			noise_q <= noise_d;
			manual_q <= manual_d;
			irq_stat_q <= irq_stat_d;
			irq_mask_q <= irq_mask_d;
			rdata_q <= rdata_d;
			delay_q <= delay_d;
		end
	end

	assign o_rdata = rdata_q;
	assign o_sample_delay = delay_q;
	assign o_supply_noise_suppress = noise_q[NOISE_BIT];
	assign o_cal_busy = running;
	assign o_irq = |(irq_stat_q & irq_mask_q);
endmodule // stc_sysref_cal

//--- core/stc_sysref_edge.sv
// sysref level register and rising edge detector
`timescale 1ns/10ps
module stc_sysref_edge (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_sysref,
	output logic o_level,
	output logic o_rise
);
	logic lvl_q;
	logic lvl_d;
	logic prev_q;
	logic prev_d;

	always_comb begin
		lvl_d = i_sysref;
		prev_d = lvl_q;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			lvl_q <= 1'b0;
			prev_q <= 1'b0;
		end else begin
			lvl_q <= lvl_d;
			prev_q <= prev_d;
		end
	end

	assign o_level = lvl_q;
	assign o_rise = lvl_q & ~prev_q;
endmodule // stc_sysref_edge

//--- test/stc_sysref_cal_monitor.sv
// port checker for the sysref calibration block
`timescale 1ns/10ps
module stc_sysref_cal_monitor import stc_pkg::*; #(
	parameter int P_BOUND_BASE = BOUND_BASE
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic i_sysref,
	input wire logic [DATA_W-1:0] o_rdata,
	input wire logic [DELAY_W-1:0] o_sample_delay,
	input wire logic o_supply_noise_suppress,
	input wire logic o_cal_busy,
	input wire logic o_irq
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	logic en_q;
	logic mz_q;
	logic [7:0] cfg_q;
	logic [DELAY_W-1:0] man_q;
	int quiet_q;
	int en_cnt_q;
	int run_q;
	int bound;
	assign bound = P_BOUND_BASE << (2 * (int'(cfg_q[3:2]) + int'(cfg_q[1:0]) + 2));
	// shadows of the enable, config, manual and irq mask registers, so reads are judged without looking inside
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			en_q <= 1'b0;
			mz_q <= 1'b1;
			cfg_q <= CONFIG_RST;
			man_q <= MANUAL_RST;
			quiet_q <= 0;
			en_cnt_q <= 0;
			run_q <= 0;
		end else begin
			if (i_wr && i_addr == OFF_ENABLE) en_q <= i_wdata[EN_BIT];
			if (i_wr && i_addr == OFF_CONFIG) cfg_q <= i_wdata[7:0];
			if (i_wr && i_addr == OFF_MANUAL) man_q <= i_wdata[DELAY_W-1:0];
			if (i_wr && i_addr == OFF_IRQ_MASK) mz_q <= i_wdata[IRQ_W-1:0] == 2'h0;
			quiet_q <= (i_wr && (i_addr == OFF_ENABLE || i_addr == OFF_MANUAL)) ? 0 : quiet_q + 1;
			en_cnt_q <= en_q ? en_cnt_q + 1 : 0;
			run_q <= o_cal_busy ? run_q + 1 : 0;
		end
	end
	sequence cfg_rd_s;
		i_rd && i_addr == OFF_CONFIG;
	endsequence
	sequence st_rd_s;
		i_rd && i_addr == OFF_STATUS && !en_q;
	endsequence
	rdata_idle_a: assert property (!i_rd |=> o_rdata == '0) else $error("idle read data");
	cfg_read_a: assert property (cfg_rd_s |=> o_rdata == {16'h0000, $past(cfg_q)}) else $error("config");
	noise_bit_a: assert property (i_wr && i_addr == OFF_NOISE |=>
		o_supply_noise_suppress == $past(i_wdata[NOISE_BIT])) else $error("noise bit");
	manual_delay_a: assert property (!en_q && quiet_q >= 3 |-> o_sample_delay == man_q) else $error("manual");
	cal_start_a: assert property ($rose(en_q) |-> ##[0:1] o_cal_busy) else $error("no start");
	off_idle_a: assert property (!en_q && !(i_wr && i_addr == OFF_ENABLE) |=> !o_cal_busy) else $error("busy");
	no_restart_a: assert property (en_cnt_q >= 4 && !o_cal_busy |=> !o_cal_busy) else $error("restart");
	run_bound_a: assert property (o_cal_busy |-> run_q <= bound + 2) else $error("run too long");
	done_en_a: assert property (st_rd_s |=> !o_rdata[DONE_BIT]) else $error("done while off");
	irq_mask_a: assert property (mz_q && !(i_wr && i_addr == OFF_IRQ_MASK) |=> !o_irq) else $error("irq masked");
endmodule // stc_sysref_cal_monitor
bind stc_sysref_cal stc_sysref_cal_monitor #(.P_BOUND_BASE(P_BOUND_BASE)) mon_u (.*);

//--- test/stc_sysref_cal_tb.sv
// self-checking bench for the sysref calibration block
`timescale 1ns/10ps
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin failures++; $display("wrong value %s %h %h", n, e, a); end end
module stc_sysref_cal_tb import stc_pkg::*;;
	logic i_clk, i_rst, i_wr, i_rd, i_sysref, gen_run, o_noise, o_busy, o_irq;
	logic [ADDR_W-1:0] i_addr;
	logic [DATA_W-1:0] i_wdata, o_rdata, d;
	logic [DELAY_W-1:0] o_delay, res;
	logic [ADDR_W-1:0] offs [6] = '{OFF_ENABLE, OFF_CONFIG, OFF_NOISE, OFF_MANUAL, OFF_IRQ_MASK, 12'h02b3};
	logic [7:0] rstv [6] = '{8'h00, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00};
	int failures = 0;
	int cmp_count = 0;
	int cyc = 0;
	stc_sysref_gen gen_u (.i_clk(i_clk), .i_run(gen_run), .o_sysref(i_sysref));
	stc_sysref_cal #(.P_BOUND_BASE(40), .P_MAX_PER_0(64)) dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_sysref(i_sysref), .o_rdata(o_rdata),
		.o_sample_delay(o_delay), .o_supply_noise_suppress(o_noise), .o_cal_busy(o_busy), .o_irq(o_irq));
	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= v;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask
	task automatic settle;
		repeat (2) @(posedge i_clk);
		#1;
	endtask
	// polling is bounded; the run bound itself is judged by the checker
	task automatic wait_irq(input int b);
		d = '0;
		for (int k = 0; k < 400 && d[b] !== 1'b1; k++) rd(OFF_IRQ_STAT);
		`CHK("irq status", 1'b1, d[b])
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			report_and_stop;
		end
	end
	initial begin
		i_rst = 1'b1;
		i_addr = '0;
		i_wdata = '0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		gen_run = 1'b0;
		repeat (10) @(posedge i_clk);
		i_rst <= 1'b0;
		wr(12'h02b3, 24'hff_ffff);
		foreach (offs[i]) begin
			rd(offs[i]);
			`CHK("reset value", {16'h0000, rstv[i]}, d)
		end
		for (int v = 1; v >= 0; v--) begin
			wr(OFF_NOISE, 24'(v) << NOISE_BIT);
			#1 `CHK("noise", v[0], o_noise)
		end
		wr(OFF_NOISE, 24'h00_0010);
		#1 `CHK("noise kept", 1'b1, o_noise)
		wr(OFF_MANUAL, 24'h01_abcd);
		settle;
		`CHK("manual delay", 17'h1_abcd, o_delay)
		wr(OFF_CONFIG, 24'h00_0000);
		wr(OFF_IRQ_MASK, 24'h00_0003);
		gen_run <= 1'b1;
		for (int r = 0; r < 2; r++) begin
			if (r == 1) wr(OFF_CONFIG, 24'h00_0005);
			wr(OFF_ENABLE, 24'h00_0001);
			wait_irq(IRQ_DONE_BIT);
			rd(OFF_STATUS);
			`CHK("complete", 1'b1, d[DONE_BIT])
			`CHK("irq line", 1'b1, o_irq)
			res = d[DELAY_W-1:0];
			`CHK("result", r ? 17'h0_070b : 17'h0_1304, res)
			wr(OFF_MANUAL, 24'h00_0055);
			wr(OFF_ENABLE, 24'h00_0001);
			settle;
			`CHK("applied delay", res, o_delay)
			`CHK("busy", 1'b0, o_busy)
			wr(OFF_IRQ_STAT, 24'h00_0003);
			wr(OFF_ENABLE, 24'h00_0000);
			settle;
			`CHK("irq cleared", 1'b0, o_irq)
			`CHK("manual back", 17'h0_0055, o_delay)
			rd(OFF_STATUS);
			`CHK("complete off", 1'b0, d[DONE_BIT])
			if (r == 0) begin
				gen_run <= 1'b0;
				wr(OFF_IRQ_MASK, 24'h00_0000);
				wr(OFF_ENABLE, 24'h00_0001);
				wait_irq(IRQ_FAIL_BIT);
				`CHK("irq masked", 1'b0, o_irq)
				rd(OFF_STATUS);
				`CHK("no complete", 1'b0, d[DONE_BIT])
				wr(OFF_IRQ_MASK, 24'h00_0003);
				settle;
				`CHK("irq unmasked", 1'b1, o_irq)
				wr(OFF_IRQ_STAT, 24'h00_0003);
				wr(OFF_ENABLE, 24'h00_0000);
				gen_run <= 1'b1;
			end
		end
		report_and_stop;
	end
endmodule // stc_sysref_cal_tb

//--- test/stc_sysref_gen.sv
// periodic sysref source for the calibration input
`timescale 1ns/10ps
module stc_sysref_gen #(
	parameter int P_PER = 24,
	parameter int P_HIGH = 12
) (
	input wire logic i_clk,
	input wire logic i_run,
	output logic o_sysref
);
	int cnt_q = 0;
	// stopped source sits low, which makes the block time out on its edge wait
	always @(posedge i_clk) begin
		cnt_q <= (cnt_q + 1) % P_PER;
		o_sysref <= i_run && cnt_q < P_HIGH;
	end
endmodule // stc_sysref_gen
